/* File: common/rtcaw_pkg.sv */
// Shared constants and types for the clock/calendar register block.
// Assumes a single 20 MHz system clock and a synchronous reset.
package rtcaw_pkg;

	localparam int CLK_HZ = 20_000_000;
	localparam int CLK_MHZ = CLK_HZ / 1_000_000;
	// Timebase: 1024 Hz enable, half of it is the 512 Hz test square
	localparam int TB_HZ = 1024;
	localparam int TB_CYC_DEF = CLK_HZ / TB_HZ;
	localparam logic [5:0] SIXT_LAST = 6'h3f;
	localparam logic [3:0] SEC_LAST = 4'hf;
	// Flag register access must be held this long to count
	localparam int RC_NS = 100;
	localparam int RC_CYC = (RC_NS * CLK_MHZ + 999) / 1000 < 1 ? 1 :
		(RC_NS * CLK_MHZ + 999) / 1000;
	// Read-freeze must stay clear this long before updates resume
	localparam int RHOLD_US = 500;
	localparam int RHOLD_CYC_DEF = RHOLD_US * CLK_MHZ;

	localparam logic [3:0] A_FLAGS = 4'h0;
	localparam logic [3:0] A_AL_SEC = 4'h2;
	localparam logic [3:0] A_AL_DATE = 4'h5;
	localparam logic [3:0] A_INTR = 4'h6;
	localparam logic [3:0] A_WDOG = 4'h7;
	localparam logic [3:0] A_CTRL = 4'h8;
	localparam logic [3:0] A_SEC = 4'h9;
	localparam logic [3:0] A_DAY = 4'hc;

	localparam int B_WFRZ = 7;
	localparam int B_RFRZ = 6;
	localparam int B_OSC = 7;
	localparam int B_FT = 6;
	localparam int B_AE = 7;
	localparam int B_ABE = 5;
	localparam int B_WDS = 7;
	localparam int B_MASK = 7;

	typedef logic [7:0][7:0] rtcaw_time_t;
	// Index 0 century, 1 sec, 2 min, 3 hour, 4 day, 5 date, 6 month, 7 year
	localparam rtcaw_time_t TMASK = {8'hff, 8'h1f, 8'h3f, 8'h07,
		8'h3f, 8'h7f, 8'h7f, 8'h3f};
	localparam logic [15:0][7:0] REGS_RST = {{6{8'h00}}, 8'h80, {9{8'h00}}};

	typedef struct packed {
		logic cs_n;
		logic ce_n;
		logic we_n;
		logic oe_n;
		logic [3:0] addr;
		logic [7:0] dq;
	} rtcaw_bus_s;

	typedef enum logic [2:0] {
		CY_IDLE = 3'b001,
		CY_READ = 3'b010,
		CY_WRITE = 3'b100
	} rtcaw_cyc_e;

endpackage

/* File: design/rtcaw_bcd_count.sv */
// Internal BCD time and calendar count, 24-hour, leap years by year/4.
// Assumes one-cycle second ticks and load pulses from the same clock.
`timescale 1ns/1ps
`default_nettype none
module rtcaw_bcd_count (
	input wire logic i_clk,
	input wire logic i_reset,
	input wire logic i_tick,
	input wire logic i_load,
	input wire rtcaw_pkg::rtcaw_time_t i_val,
	output rtcaw_pkg::rtcaw_time_t o_time
);
	import rtcaw_pkg::*;

	rtcaw_time_t t_q, t_d;

	function automatic logic [8:0] step(input logic [7:0] v,
		input logic [7:0] mx, input logic [7:0] mn, input logic en);
		if (!en)
			step = {1'b0, v};
		else if (v >= mx)
			step = {1'b1, mn};
		else if (v[3:0] == 4'h9)
			step = {1'b0, v[7:4] + 4'h1, 4'h0};
		else
			step = {1'b0, v + 8'h01};
	endfunction

	function automatic logic [7:0] mdays(input logic [7:0] mo,
		input logic [7:0] yr);
		logic [1:0] m4;
		m4 = {yr[4], 1'b0} + yr[1:0];
		case (mo)
			8'h02: mdays = (m4 == 2'h0) ? 8'h29 : 8'h28;
			8'h04, 8'h06, 8'h09, 8'h11: mdays = 8'h30;
			default: mdays = 8'h31;
		endcase
	endfunction

	always_comb begin
		logic c;
		logic [8:0] r;
		c = 1'b0;
		r = 9'h000;
		t_d = t_q;
		if (i_load) begin
			for (int i = 0; i < 8; i++)
				t_d[i] = i_val[i] & TMASK[i];
		end else if (i_tick) begin
			{c, t_d[1]} = step(t_q[1], 8'h59, 8'h00, 1'b1);
			{c, t_d[2]} = step(t_q[2], 8'h59, 8'h00, c);
			{c, t_d[3]} = step(t_q[3], 8'h23, 8'h00, c);
			r = step(t_q[4], 8'h07, 8'h01, c);
			t_d[4] = r[7:0];
			{c, t_d[5]} = step(t_q[5], mdays(t_q[6], t_q[7]), 8'h01, c);
			{c, t_d[6]} = step(t_q[6], 8'h12, 8'h01, c);
			{c, t_d[7]} = step(t_q[7], 8'h99, 8'h00, c);
			r = step(t_q[0], 8'h39, 8'h00, c);
			t_d[0] = r[7:0];
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_reset)
			t_q <= '0;
		else
			t_q <= t_d;
	end

	assign o_time = t_q;

endmodule // rtcaw_bcd_count
`default_nettype wire

/* File: design/rtcaw_core.sv */
// Clock/calendar register block with alarm, watchdog and frequency test.
// Assumes asynchronous host pins, synchronised here; one 20 MHz clock.
`timescale 1ns/1ps
`default_nettype none
module rtcaw_core #(
	parameter int TB_CYC = rtcaw_pkg::TB_CYC_DEF,
	parameter int RHOLD_CYC = rtcaw_pkg::RHOLD_CYC_DEF
) (
	input wire logic i_clk,
	input wire logic i_reset,
	input wire rtcaw_pkg::rtcaw_bus_s i_bus,
	input wire logic i_backup,
	input wire logic i_power_up,
	output logic [7:0] o_dq,
	output logic o_dq_oe,
	output logic o_irq_out,
	output logic o_irq_oe
);
	import rtcaw_pkg::*;

	localparam int TW = $clog2(TB_CYC);
	localparam int RW = $clog2(RHOLD_CYC + 1);

	if (TB_CYC < 2 || RHOLD_CYC < 1) begin : g_chk
		$error("rtcaw_core: divider or hold count too small");
	end

	// Pin synchronisers
	rtcaw_bus_s bus_m_q, bus_s_q;
	logic bk_m_q, bk_s_q, pu_m_q, pu_s_q;

	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			bus_m_q <= '1;
			bus_s_q <= '1;
			{bk_m_q, bk_s_q, pu_m_q, pu_s_q} <= 4'h0;
		end else begin
			bus_m_q <= i_bus;
			bus_s_q <= bus_m_q;
			{bk_m_q, pu_m_q} <= {i_backup, i_power_up};
			{bk_s_q, pu_s_q} <= {bk_m_q, pu_m_q};
		end
	end

	// Host inputs are ignored while on battery
	logic sel, wr_act, rd_act, strobe;
	assign sel = ~bus_s_q.cs_n & bus_s_q.ce_n & ~bk_s_q;
	assign wr_act = sel & ~bus_s_q.we_n;
	assign rd_act = sel & bus_s_q.we_n;
	assign strobe = sel & (~bus_s_q.we_n | ~bus_s_q.oe_n);

	// Bus cycle tracking
	rtcaw_cyc_e st_q, st_d;
	logic [3:0] adr_q, adr_d;
	logic [7:0] wdat_q, wdat_d;
	logic wr_stb, rd_end;

	always_comb begin
		st_d = st_q;
		adr_d = adr_q;
		wdat_d = wdat_q;
		wr_stb = 1'b0;
		rd_end = 1'b0;
		case (st_q)
			CY_IDLE: begin
				adr_d = bus_s_q.addr;
				wdat_d = bus_s_q.dq;
				if (wr_act)
					st_d = CY_WRITE;
				else if (rd_act)
					st_d = CY_READ;
			end
			CY_READ: begin
				if (!rd_act) begin
					rd_end = 1'b1;
					st_d = wr_act ? CY_WRITE : CY_IDLE;
				end
				adr_d = bus_s_q.addr;
				wdat_d = bus_s_q.dq;
			end
			CY_WRITE: begin
				// Latest data before the earlier rising edge is kept
				if (!wr_act) begin
					wr_stb = 1'b1;
					st_d = rd_act ? CY_READ : CY_IDLE;
					adr_d = bus_s_q.addr;
				end else begin
					wdat_d = bus_s_q.dq;
				end
			end
			default: st_d = CY_IDLE;
		endcase
	end

	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			st_q <= CY_IDLE;
			adr_q <= 4'h0;
			wdat_q <= 8'h00;
		end else begin
			st_q <= st_d;
			adr_q <= adr_d;
			wdat_q <= wdat_d;
		end
	end

	// Register file and flags
	logic [15:0][7:0] regs_q, regs_d;
	logic af_q, af_d, wf_q, wf_d, load_q, load_d;
	logic [RW-1:0] rcnt_q, rcnt_d;
	logic [1:0] fa_q, fa_d;
	logic clr_q, clr_d;
	rtcaw_time_t tnow;
	logic osc_stop, rfrz, wfrz, ae, abe, watchdog_steering_bit, resumed;
	logic alarm_ev, wd_hit, wd_access, flag_end;

	assign osc_stop = regs_q[A_SEC][B_OSC];
	assign rfrz = regs_q[A_CTRL][B_RFRZ];
	assign wfrz = regs_q[A_CTRL][B_WFRZ];
	assign ae = regs_q[A_INTR][B_AE];
	assign abe = regs_q[A_INTR][B_ABE];
	assign watchdog_steering_bit = regs_q[A_WDOG][B_WDS];
	assign resumed = rcnt_q == RW'(RHOLD_CYC);
	assign wd_access = (wr_stb | rd_end) & (adr_q == A_WDOG);
	assign flag_end = clr_q & ~strobe;

	always_comb begin
		regs_d = regs_q;
		af_d = af_q;
		wf_d = wf_q;
		load_d = 1'b0;
		rcnt_d = rfrz ? '0 : (resumed ? rcnt_q : rcnt_q + RW'(1));
		fa_d = 2'h0;
		clr_d = clr_q;
		if (!rfrz && !wfrz && resumed) begin
			for (int i = 0; i < 8; i++)
				regs_d[8 + i] = (regs_q[8 + i] & ~TMASK[i]) | tnow[i];
		end
		if (wr_stb && adr_q != A_FLAGS)
			regs_d[adr_q] = wdat_q;
		if (wr_stb && adr_q == A_CTRL && wfrz && !wdat_q[B_WFRZ])
			load_d = 1'b1;
		if (pu_s_q) begin
			regs_d[A_INTR][B_AE] = 1'b0;
			regs_d[A_INTR][B_ABE] = 1'b0;
		end
		// Access must sit on the flag address for the full read time
		if (strobe && bus_s_q.addr == A_FLAGS && !clr_q) begin
			fa_d = fa_q + 2'h1;
			if (fa_q == 2'(RC_CYC - 1))
				clr_d = 1'b1;
		end
		if (flag_end) begin
			clr_d = 1'b0;
			af_d = 1'b0;
			wf_d = 1'b0;
		end
		if (wd_access)
			wf_d = 1'b0;
		// New events win over a clear in the same cycle
		if (alarm_ev)
			af_d = 1'b1;
		if (wd_hit)
			wf_d = 1'b1;
	end

	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			regs_q <= REGS_RST;
			{af_q, wf_q, load_q, clr_q} <= 4'h0;
			rcnt_q <= '0;
			fa_q <= 2'h0;
		end else begin
			regs_q <= regs_d;
			{af_q, wf_q, load_q, clr_q} <= {af_d, wf_d, load_d, clr_d};
			rcnt_q <= rcnt_d;
			fa_q <= fa_d;
		end
	end

	// Timebase; stopped oscillator freezes all counting
	logic [TW-1:0] tb_q, tb_d;
	logic [5:0] sub_q, sub_d;
	logic [3:0] sc_q, sc_d;
	logic sq_q, sq_d, ts_q, tick1k, tick16, tick_s;

	assign tick1k = ~osc_stop & (tb_q == TW'(TB_CYC - 1));
	assign tick16 = tick1k & (sub_q == SIXT_LAST);
	assign tick_s = tick16 & (sc_q == SEC_LAST);

	always_comb begin
		tb_d = osc_stop ? tb_q : (tick1k ? '0 : tb_q + TW'(1));
		sub_d = tick1k ? sub_q + 6'h01 : sub_q;
		sc_d = tick16 ? sc_q + 4'h1 : sc_q;
		sq_d = tick1k ? ~sq_q : sq_q;
	end

	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			tb_q <= '0;
			sub_q <= 6'h00;
			sc_q <= 4'h0;
			{sq_q, ts_q} <= 2'h0;
		end else begin
			tb_q <= tb_d;
			sub_q <= sub_d;
			sc_q <= sc_d;
			{sq_q, ts_q} <= {sq_d, tick_s};
		end
	end

	rtcaw_bcd_count u_count (
		.i_clk(i_clk),
		.i_reset(i_reset),
		.i_tick(tick_s),
		.i_load(load_q),
		.i_val(regs_q[15:8]),
		.o_time(tnow)
	);

	// Alarm compare one cycle after the count moved
	function automatic logic al_hit(input logic [3:0] m,
		input logic [3:0] eq);
		case (m)
			4'b1110: al_hit = eq[0];
			4'b1100: al_hit = &eq[1:0];
			4'b1000: al_hit = &eq[2:0];
			4'b0000: al_hit = &eq;
			default: al_hit = 1'b1;
		endcase
	endfunction

	logic [3:0] al_mask, al_eq;
	assign al_mask = {regs_q[A_AL_DATE][B_MASK], regs_q[4][B_MASK],
		regs_q[3][B_MASK], regs_q[A_AL_SEC][B_MASK]};
	assign al_eq = {tnow[5][5:0] == regs_q[A_AL_DATE][5:0],
		tnow[3][5:0] == regs_q[4][5:0], tnow[2][6:0] == regs_q[3][6:0],
		tnow[1][6:0] == regs_q[A_AL_SEC][6:0]};
	assign alarm_ev = ts_q & al_hit(al_mask, al_eq);

	// Watchdog in sixteenth-second steps
	function automatic logic [10:0] wd_lim(input logic [7:0] r);
		case (r[1:0])
			2'b00: wd_lim = {6'h00, r[6:2]};
			2'b01: wd_lim = {4'h0, r[6:2], 2'b00};
			2'b10: wd_lim = {2'b00, r[6:2], 4'h0};
			default: wd_lim = {r[6:2], 6'h00};
		endcase
	endfunction

	// Own sixteenth divider, restarted on access so no step is cut short
	logic [10:0] wd_q, wd_d;
	logic [5:0] wsub_q, wsub_d;
	logic wd_tick;
	assign wd_tick = tick1k & (wsub_q == SIXT_LAST);
	always_comb begin
		wd_d = wd_q;
		wsub_d = tick1k ? wsub_q + 6'h01 : wsub_q;
		wd_hit = 1'b0;
		if (wd_access) begin
			wd_d = 11'h000;
			wsub_d = 6'h00;
		end else if (wd_tick && regs_q[A_WDOG][6:2] != 5'h00 && !wf_q) begin
			if (wd_q + 11'h001 >= wd_lim(regs_q[A_WDOG])) begin
				wd_hit = 1'b1;
				wd_d = 11'h000;
			end else begin
				wd_d = wd_q + 11'h001;
			end
		end
	end

	// Interrupt/test pin and read data
	logic ft_on, irq_d;
	logic [7:0] dq_d;
	assign ft_on = regs_q[A_DAY][B_FT] & ~ae & ~osc_stop &
		(watchdog_steering_bit | regs_q[A_WDOG] == 8'h00);
	always_comb begin
		if (ft_on)
			irq_d = ~sq_q;
		else
			irq_d = ((af_q & ae & (~bk_s_q | abe)) |
				(wf_q & ~watchdog_steering_bit)) & ~clr_q;
		dq_d = (bus_s_q.addr == A_FLAGS) ? {wf_q, af_q, 6'h00} :
			regs_q[bus_s_q.addr];
	end

	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			wd_q <= 11'h000;
			wsub_q <= 6'h00;
			o_irq_oe <= 1'b0;
			o_dq <= 8'h00;
		end else begin
			wd_q <= wd_d;
			wsub_q <= wsub_d;
			o_irq_oe <= irq_d;
			o_dq <= dq_d;
		end
	end

	assign o_dq_oe = (st_q == CY_READ) & rd_act & ~bus_s_q.oe_n;
	assign o_irq_out = 1'b0;

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_reset);

	sequence s_flag_held;
		clr_q && !flag_end;
	endsequence
	sequence s_flag_done;
		flag_end && !alarm_ev && !wd_hit && !ft_on;
	endsequence

	a_read_drive: assert property (rd_act && !bus_s_q.oe_n ##1
		rd_act && !bus_s_q.oe_n |-> o_dq_oe) else $error("read not driven");
	a_we_kills_out: assert property (!bus_s_q.we_n |->
		!o_dq_oe) else $error("drivers on during write strobe");
	a_osc_halts: assert property (osc_stop && !load_q |=>
		$stable(tnow)) else $error("time moved with oscillator stopped");
	a_rfreeze_hold: assert property (rfrz && !wr_stb |=>
		$stable(regs_q[15:9])) else $error("frozen time changed");
	a_wfreeze_load: assert property (wr_stb && adr_q == A_CTRL &&
		wfrz && !wdat_q[B_WFRZ] |=> load_q ##1
		tnow[1] == ($past(regs_q[A_SEC]) & TMASK[1]))
		else $error("no count load");
	a_ft_square: assert property (ft_on ##1 ft_on |->
		o_irq_oe == !$past(sq_q)) else $error("test square wrong");
	a_alarm_flag: assert property (alarm_ev |=> af_q)
		else $error("alarm flag not set");
	a_flag_clear: assert property (s_flag_held ##1 s_flag_done |=>
		!af_q && !wf_q && !o_irq_oe) else $error("flags not cleared");
	a_pwrup_enables: assert property (pu_s_q |=> !ae && !abe)
		else $error("enables not cleared at power-up");
	a_wd_expire: assert property (wd_hit |=> wf_q && wd_q == 11'h000)
		else $error("watchdog expiry lost");
	a_wd_restart: assert property (wd_access |=> wd_q == 11'h000 &&
		!wf_q) else $error("watchdog access did not restart");
	a_wd_off: assert property (regs_q[A_WDOG][6:2] == 5'h00 |=>
		!$rose(wf_q)) else $error("disabled watchdog fired");
	a_por_defaults: assert property ($past(i_reset) |->
		regs_q[A_WDOG] == 8'h00 && !ae && !abe && !regs_q[A_DAY][B_FT])
		else $error("power-up defaults wrong");

endmodule // rtcaw_core
`default_nettype wire

/* File: test/rtcaw_host_model.sv */
// Host processor model driving the clock register pins.
// Assumes bench calls its tasks just after a rising edge.
`timescale 1ns/1ps
`default_nettype none
module rtcaw_host_model (
	input wire logic i_clk,
	input wire logic [7:0] i_dq,
	input wire logic i_dq_oe,
	output var rtcaw_pkg::rtcaw_bus_s o_bus
);
	import rtcaw_pkg::*;
	rtcaw_bus_s bus_q = '{1'b1, 1'b1, 1'b1, 1'b1, 4'h0, 8'h00};
	logic [7:0] hdq_q = 8'h00;
	logic hdrv_q = 1'b0;
	logic [7:0] last_q = 8'h00;
	int hold_cyc = 4;
	// Released lines invert the last value, no stale data
	always_comb begin
		o_bus = bus_q;
		o_bus.dq = hdrv_q ? hdq_q : (i_dq_oe ? i_dq : ~last_q);
	end
	always @(posedge i_clk) last_q <= o_bus.dq;
	// Address set a clock ahead of any strobe
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		bus_q.addr <= a;
		@(posedge i_clk);
		bus_q.oe_n <= 1'b1;
		bus_q.cs_n <= 1'b0;
		bus_q.we_n <= 1'b0;
		hdq_q <= d;
		hdrv_q <= 1'b1;
		repeat (hold_cyc) @(posedge i_clk);
		bus_q.we_n <= 1'b1;
		bus_q.cs_n <= 1'b1;
		hdrv_q <= 1'b0;
		repeat (4) @(posedge i_clk);
	endtask
	task automatic rd(input logic [3:0] a, output logic [7:0] d,
		output bit ok);
		bus_q.addr <= a;
		@(posedge i_clk);
		bus_q.cs_n <= 1'b0;
		bus_q.oe_n <= 1'b0;
		ok = 1'b0;
		d = 8'hxx;
		for (int i = 0; i < 12 && !ok; i++) begin
			@(posedge i_clk);
			if (i_dq_oe === 1'b1) begin
				ok = 1'b1;
				d = i_dq;
			end
		end
		bus_q.cs_n <= 1'b1;
		bus_q.oe_n <= 1'b1;
		repeat (4) @(posedge i_clk);
	endtask
endmodule // rtcaw_host_model
`default_nettype wire

/* File: test/rtcaw_core_tb.sv */
// Self-checking bench for the clock register block.
// Assumes the host model drives pins; timebase shortened to 4 clocks.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin \
	checks_done++; \
	if ((g) !== (e)) begin \
		mismatches++; \
		$display("MISMATCH %s exp %h got %h", nm, e, g); \
	end \
end
module rtcaw_core_tb;
	import rtcaw_pkg::*;
	localparam int TBC = 4;
	logic i_clk;
	logic i_reset;
	logic i_power_up;
	logic i_backup;
	rtcaw_bus_s bus;
	logic [7:0] o_dq;
	logic o_dq_oe;
	logic o_irq_out;
	logic o_irq_oe;
	int mismatches = 0;
	int checks_done = 0;

	rtcaw_core #(.TB_CYC(TBC), .RHOLD_CYC(8)) u_dut (
		.i_clk(i_clk), .i_reset(i_reset), .i_bus(bus), .i_backup(i_backup),
		.i_power_up(i_power_up), .o_dq(o_dq), .o_dq_oe(o_dq_oe),
		.o_irq_out(o_irq_out), .o_irq_oe(o_irq_oe));
	rtcaw_host_model u_host (.i_clk(i_clk), .i_dq(o_dq),
		.i_dq_oe(o_dq_oe), .o_bus(bus));

	task automatic rdc(input logic [3:0] a, input logic [7:0] m,
		input logic [7:0] e);
		logic [7:0] d;
		bit ok;
		u_host.rd(a, d, ok);
		`CHK("read drive", 1'b1, ok)
		`CHK("read data", e, d & m)
	endtask
	task automatic toggles(input int n, output int t);
		logic p;
		t = 0;
		p = o_irq_oe;
		repeat (n) begin
			@(posedge i_clk);
			if (o_irq_oe !== p) t++;
			p = o_irq_oe;
		end
	endtask
	task automatic t_reset_vals();
		for (int a = 0; a < 16; a++) begin
			rdc(4'(a), 8'hff, REGS_RST[a]);
		end
		`CHK("irq idle", 1'b0, o_irq_oe)
		`CHK("irq pin level", 1'b0, o_irq_out)
	endtask
	task automatic t_rw();
		for (int a = 2; a < 6; a++) begin
			u_host.hold_cyc = a * 2;
			u_host.wr(4'(a), 8'h80 | 8'(a));
			rdc(4'(a), 8'hff, 8'h80 | 8'(a));
		end
		u_host.hold_cyc = 4;
		u_host.wr(A_FLAGS, 8'hff);
		rdc(A_FLAGS, 8'hff, 8'h00);
	endtask
	task automatic t_freq();
		int t;
		u_host.wr(A_CTRL, 8'h80);
		u_host.wr(A_SEC, 8'h00);
		u_host.wr(A_DAY, 8'h41);
		u_host.wr(A_CTRL, 8'h00);
		rdc(A_DAY, 8'hff, 8'h41);
		toggles(20 * TBC, t);
		`CHK("ft toggles", 1'b1, t >= 19 && t <= 21)
		u_host.wr(A_CTRL, 8'h80);
		u_host.wr(A_DAY, 8'h01);
		u_host.wr(A_CTRL, 8'h00);
		toggles(20 * TBC, t);
		`CHK("ft off", 0, t)
	endtask
	task automatic t_freeze();
		logic [7:0] d1;
		logic [7:0] d2;
		bit ok;
		u_host.wr(A_CTRL, 8'h40);
		u_host.rd(A_SEC, d1, ok);
		repeat (4500) @(posedge i_clk);
		rdc(A_SEC, 8'hff, d1);
		u_host.wr(A_CTRL, 8'h00);
		repeat (4200) @(posedge i_clk);
		u_host.rd(A_SEC, d2, ok);
		`CHK("sec moved", 1'b1, d2 !== d1)
	endtask
	task automatic t_alarm();
		int n;
		rdc(A_FLAGS, 8'h3f, 8'h00);
		u_host.wr(A_INTR, 8'h80);
		for (n = 0; n < 4400 && o_irq_oe !== 1'b1; n++) @(posedge i_clk);
		`CHK("alarm irq", 1'b1, o_irq_oe)
		rdc(A_FLAGS, 8'h40, 8'h40);
		`CHK("alarm clr", 1'b0, o_irq_oe)
		i_power_up <= 1'b1;
		repeat (6) @(posedge i_clk);
		i_power_up <= 1'b0;
		repeat (4) @(posedge i_clk);
		rdc(A_INTR, 8'ha0, 8'h00);
	endtask
	task automatic t_backup();
		u_host.wr(A_INTR, 8'h80);
		i_backup <= 1'b1;
		repeat (4400) @(posedge i_clk);
		`CHK("backup no abe", 1'b0, o_irq_oe)
		i_backup <= 1'b0;
		repeat (4) @(posedge i_clk);
		`CHK("alarm after backup", 1'b1, o_irq_oe)
		u_host.wr(A_INTR, 8'ha0);
		i_backup <= 1'b1;
		repeat (6) @(posedge i_clk);
		`CHK("backup with abe", 1'b1, o_irq_oe)
		i_backup <= 1'b0;
		repeat (4) @(posedge i_clk);
		u_host.wr(A_INTR, 8'h00);
		rdc(A_FLAGS, 8'h40, 8'h40);
	endtask
	task automatic t_wdog();
		int n;
		int x;
		for (int m = 1; m < 3; m++) begin
			// Sixteenth second is 64 timebase ticks
			x = 64 * TBC * m;
			u_host.wr(A_WDOG, 8'(m << 2));
			for (n = 0; n < 1200 && o_irq_oe !== 1'b1; n++) @(posedge i_clk);
			`CHK("wd time", 1'b1, n >= x - TBC - 4 && n <= x + TBC + 4)
			rdc(A_FLAGS, 8'h80, 8'h80);
			`CHK("wd clr", 1'b0, o_irq_oe)
		end
		u_host.wr(A_WDOG, 8'h00);
		repeat (600) @(posedge i_clk);
		`CHK("wd off", 1'b0, o_irq_oe)
	endtask
	task automatic close_out();
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	initial begin
		i_clk = 1'b0;
		forever #25 i_clk = ~i_clk;
	end
	initial begin
		i_reset = 1'b1;
		i_power_up = 1'b0;
		i_backup = 1'b0;
		repeat (5) @(posedge i_clk);
		i_reset <= 1'b0;
		@(posedge i_clk);
		t_reset_vals();
		t_rw();
		t_freq();
		t_freeze();
		t_alarm();
		t_backup();
		t_wdog();
		close_out();
	end
	// Run needs about 18500 clocks; limit leaves ample margin
	initial begin
		repeat (40000) @(posedge i_clk);
		mismatches++;
		close_out();
	end
endmodule // rtcaw_core_tb
`default_nettype wire
